// ### reset_class_decode.sv
// turns reset and wake-up events into one registered class pulse
`timescale 1ns/100ps
module reset_class_decode
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pwr_on_i,
  input  wire logic brown_out_reset_i,
  input  wire logic external_reset_pin_i,
  input  wire logic other_reset_i,
  input  wire logic watchdog_wake_i,
  input  wire logic irq_wake_i,
  output logic      cls_pwr_o,
  output logic      cls_brown_o,
  output logic      cls_other_o,
  output logic      cls_wake_o,
  output logic      wake_by_irq_o,
  output logic      wake_by_wd_o
);

  logic pin_meta_ff;
  logic pin_sync_ff;
  logic any_other;
  logic any_wake;

  assign any_other = pin_sync_ff | other_reset_i;
  assign any_wake  = watchdog_wake_i | irq_wake_i;

  always_ff @(posedge clk_i) begin
    pin_meta_ff <= external_reset_pin_i;
    pin_sync_ff <= pin_meta_ff;
  end

  // one class at a time, strongest reset first
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cls_pwr_o     <= 1'b0;
      cls_brown_o   <= 1'b0;
      cls_other_o   <= 1'b0;
      cls_wake_o    <= 1'b0;
      wake_by_irq_o <= 1'b0;
      wake_by_wd_o  <= 1'b0;
    end else begin
      cls_pwr_o     <= pwr_on_i;
      cls_brown_o   <= ~pwr_on_i & brown_out_reset_i;
      cls_other_o   <= ~pwr_on_i & ~brown_out_reset_i & any_other;
      cls_wake_o    <= ~pwr_on_i & ~brown_out_reset_i & ~any_other & any_wake;
      wake_by_irq_o <= ~pwr_on_i & ~brown_out_reset_i & ~any_other & irq_wake_i;
      wake_by_wd_o  <= ~pwr_on_i & ~brown_out_reset_i & ~any_other & watchdog_wake_i;
    end
  end

endmodule

// ### reset_init_pkg.sv
// constants, register map and per-condition initial value tables
package reset_init_pkg;

  localparam int NREG   = 30;
  localparam int ADDR_W = 8;
  localparam int IDX_W  = 5;
  localparam int PC_W   = 21;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PTR1_HI   = 5'h00;
  localparam logic [IDX_W-1:0] IDX_PTR1_LO   = 5'h01;
  localparam logic [IDX_W-1:0] IDX_BANK_SEL  = 5'h02;
  localparam logic [IDX_W-1:0] IDX_PTR2_HI   = 5'h03;
  localparam logic [IDX_W-1:0] IDX_PTR2_LO   = 5'h04;
  localparam logic [IDX_W-1:0] IDX_ALU_FLAGS = 5'h05;
  localparam logic [IDX_W-1:0] IDX_T0_HIGH   = 5'h06;
  localparam logic [IDX_W-1:0] IDX_T0_LOW    = 5'h07;
  localparam logic [IDX_W-1:0] IDX_T0_CONFIG = 5'h08;
  localparam logic [IDX_W-1:0] IDX_OSC       = 5'h09;
  localparam logic [IDX_W-1:0] IDX_VDET      = 5'h0A;
  localparam logic [IDX_W-1:0] IDX_WATCHDOG  = 5'h0B;
  localparam logic [IDX_W-1:0] IDX_CAUSE     = 5'h0C;
  localparam logic [IDX_W-1:0] IDX_T1_HIGH   = 5'h0D;
  localparam logic [IDX_W-1:0] IDX_T1_LOW    = 5'h0E;
  localparam logic [IDX_W-1:0] IDX_T1_CONFIG = 5'h0F;
  localparam logic [IDX_W-1:0] IDX_T2_COUNT  = 5'h10;
  localparam logic [IDX_W-1:0] IDX_T2_PERIOD = 5'h11;
  localparam logic [IDX_W-1:0] IDX_T2_CONFIG = 5'h12;
  localparam logic [IDX_W-1:0] IDX_SER_BUF   = 5'h13;
  localparam logic [IDX_W-1:0] IDX_SER_ADDR  = 5'h14;
  localparam logic [IDX_W-1:0] IDX_SER_STAT  = 5'h15;
  localparam logic [IDX_W-1:0] IDX_SER_CTLA  = 5'h16;
  localparam logic [IDX_W-1:0] IDX_SER_CTLB  = 5'h17;
  localparam logic [IDX_W-1:0] IDX_STK_UPPER = 5'h18;
  localparam logic [IDX_W-1:0] IDX_STK_HIGH  = 5'h19;
  localparam logic [IDX_W-1:0] IDX_STK_LOW   = 5'h1A;
  localparam logic [IDX_W-1:0] IDX_STK_PTR   = 5'h1B;
  localparam logic [IDX_W-1:0] IDX_IRQ_CTRL  = 5'h1C;
  localparam logic [IDX_W-1:0] IDX_PORT_A    = 5'h1D;

  // field positions
  localparam int IRQ_GIE_HIGH_BIT = 7;
  localparam int IRQ_GIE_LOW_BIT  = 6;
  localparam int IRQ_WAKE_IRQ_BIT = 1;
  localparam int IRQ_WAKE_WD_BIT  = 0;
  localparam int STK_CNT_W        = 5;
  localparam int PORT_A_PINS_FREE_LO    = 6;
  localparam int PORT_A_PINS_FREE_HI    = 7;

  localparam logic [PC_W-1:0] VEC_HIGH_PRIO = 21'h00008;
  localparam logic [PC_W-1:0] VEC_LOW_PRIO  = 21'h00018;

  typedef logic [7:0] tbl_t [NREG];

  // implemented bits; all others read as zero except in port A, which reads the pins
  localparam tbl_t T_IMPL = '{8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'h1F, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hBF, 8'h01, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hDF, 8'hC3, 8'h00};
  // power-on value, shared with brown-out where not kept
  localparam tbl_t T_PWR_VAL = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h40, 8'h05, 8'h00, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam tbl_t T_PWR_Q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  // bits kept through a brown-out
  localparam tbl_t T_BRN_KEEP = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00,
    8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam tbl_t T_OTH_VAL = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h40, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam tbl_t T_OTH_KEEP = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00,
    8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hFF, 8'hFF, 8'hBF, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam tbl_t T_OTH_Q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h5C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam tbl_t T_WAK_VAL = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam tbl_t T_WAK_KEEP = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFD, 8'hFF, 8'hFF, 8'hB3, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF};
  localparam tbl_t T_WAK_Q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h4C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};

endpackage

// ### reset_init_value_bank.sv
// register bank with per-condition reset, wake-up and APB access
`timescale 1ns/100ps

// Summary of operation
// - irq wake with a global enable loads the vector 0008h or 0018h.
// - irq wake with a global enable pushes the pc and bumps the stack pointer.
// - watchdog or irq wake sets a flag naming the wake source.
// - unimplemented bits read zero except in port A, which reads the pins.
// - port A bits 6 and 7 read zero unless the clock mode frees them.
// - flagged registers clear on power-on but survive a brown-out.
// - timer 0 config loads all ones on every reset, kept on wake.
// - timer 2 period reads all ones after any reset or wake.
// - timer 1 config clears on power-on and brown-out; other resets clear bit 6 only.
// - oscillator config loads its fixed patterns; wake changes only bit 1.
// - voltage detect config loads 0-00 0101 on resets, kept on wake.
// - reset cause loads 0q-1 11q0 on power-on; q bits track later events.
// - timer 2 config clears its seven bits on resets, bit 7 absent.
// - timer 0 high, timer 2 count and serial control clear on resets.
// - pointers, timer 0 low, timer 1 bytes, alu flags, serial buffer keep through brown-out and other resets.
module reset_init_value_bank
  import reset_init_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              pwr_on_i,
  input  wire logic              brown_out_reset_i,
  input  wire logic              external_reset_pin_i,
  input  wire logic              other_reset_i,
  input  wire logic              watchdog_wake_i,
  input  wire logic              irq_wake_i,
  input  wire logic              irq_high_prio_i,
  input  wire logic [PC_W-1:0]   pc_i,
  input  wire logic [7:0]        osc_cond_i,
  input  wire logic [7:0]        cause_cond_i,
  input  wire logic              osc_frees_pins_i,
  input  wire logic [7:0]        port_a_pins_i,
  output logic                   pc_load_o,
  output logic      [PC_W-1:0]   pc_vector_o,
  output logic                   high_prio_global_irq_en_o,
  output logic                   low_prio_global_irq_en_o,
  output logic      [1:0]        wake_flags_o,
  output logic      [7:0]        osc_config_o,
  output logic      [7:0]        tmr_zero_config_o,
  output logic      [7:0]        tmr_one_config_o,
  output logic      [7:0]        tmr_two_period_o,
  output logic      [7:0]        reset_cause_o,
  output logic      [4:0]        stack_pointer_o
);

  // merge one condition's keep mask, fixed value and q bits
  function automatic logic [7:0] fold(
    input logic [7:0] cur,
    input logic [7:0] keep,
    input logic [7:0] val,
    input logic [7:0] qm,
    input logic [7:0] cond
  );
    fold = (cur & keep) | (val & ~keep & ~qm) | (cond & qm);
  endfunction

  logic [7:0]      regs_ff [NREG];
  logic [7:0]      wr_val  [NREG];
  logic [7:0]      push_val[NREG];
  logic [7:0]      set_val [NREG];
  logic [7:0]      cond_val[NREG];

  logic            cls_pwr;
  logic            cls_brown;
  logic            cls_other;
  logic            cls_wake;
  logic            wake_by_irq;
  logic            wake_by_wd;
  logic            push;
  logic [PC_W-1:0] pc_saved;

  logic            setup_ph;
  logic            access_ph;
  logic [IDX_W-1:0] idx;
  logic            aligned;
  logic            idx_ok;
  logic            hit;
  logic            wr_en;
  logic [7:0]      wbyte;

  logic [7:0]      port_a_pins_meta_ff;
  logic [7:0]      port_a_pins_sync_ff;
  logic [7:0]      port_a_pins_view;
  logic [7:0]      rd_byte;
  logic [31:0]     rdata_ff;
  logic            err_ff;

  logic [STK_CNT_W-1:0] sp_cnt;
  logic [STK_CNT_W-1:0] nxt_sp_cnt;

  reset_class_decode u_class (
    .clk_i                (clk_i),
    .reset_i              (reset_i),
    .pwr_on_i             (pwr_on_i),
    .brown_out_reset_i    (brown_out_reset_i),
    .external_reset_pin_i (external_reset_pin_i),
    .other_reset_i        (other_reset_i),
    .watchdog_wake_i      (watchdog_wake_i),
    .irq_wake_i           (irq_wake_i),
    .cls_pwr_o            (cls_pwr),
    .cls_brown_o          (cls_brown),
    .cls_other_o          (cls_other),
    .cls_wake_o           (cls_wake),
    .wake_by_irq_o        (wake_by_irq),
    .wake_by_wd_o         (wake_by_wd)
  );

  wake_vector_unit u_wake (
    .clk_i           (clk_i),
    .reset_i         (reset_i),
    .cls_wake_i      (cls_wake),
    .wake_by_irq_i   (wake_by_irq),
    .gie_high_i      (high_prio_global_irq_en_o),
    .gie_low_i       (low_prio_global_irq_en_o),
    .irq_high_prio_i (irq_high_prio_i),
    .pc_i            (pc_i),
    .push_o          (push),
    .pc_load_o       (pc_load_o),
    .pc_saved_o      (pc_saved),
    .pc_vector_o     (pc_vector_o)
  );

  // apb decode; registers sit one per aligned word
  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign idx       = paddr_i[IDX_W+1:2];
  assign aligned   = (paddr_i[1:0] == 2'h0);
  assign idx_ok    = (32'(idx) < NREG);
  assign hit       = aligned & idx_ok;
  assign wr_en     = access_ph & pwrite_i & hit;
  assign wbyte     = pwdata_i[7:0];

  // zero wait states: read data is captured in setup
  assign pready_o  = 1'b1;
  assign prdata_o  = rdata_ff;
  assign pslverr_o = err_ff;

  // pins come from outside the clock domain
  always_ff @(posedge clk_i) begin
    port_a_pins_meta_ff <= port_a_pins_i;
    port_a_pins_sync_ff <= port_a_pins_meta_ff;
  end

  always_comb begin
    port_a_pins_view = port_a_pins_sync_ff;
    if (!osc_frees_pins_i) begin
      port_a_pins_view[PORT_A_PINS_FREE_HI] = 1'b0;
      port_a_pins_view[PORT_A_PINS_FREE_LO] = 1'b0;
    end
  end

  assign rd_byte = (idx == IDX_PORT_A) ? port_a_pins_view : regs_ff[idx];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_ff <= 32'h0;
      err_ff   <= 1'b0;
    end else if (setup_ph) begin
      rdata_ff <= (hit && !pwrite_i) ? {24'h0, rd_byte} : 32'h0;
      err_ff   <= ~hit;
    end
  end

  // stack counter advances on every interrupt push
  assign sp_cnt     = regs_ff[IDX_STK_PTR][STK_CNT_W-1:0];
  assign nxt_sp_cnt = sp_cnt + 5'h01;

  genvar i;
  generate
    for (i = 0; i < NREG; i++) begin : g_reg
      logic [7:0] cur;
      logic [7:0] base;
      logic [7:0] nxt_reg;
      logic       this_wr;
      logic       this_push;

      assign cur     = regs_ff[i];
      assign this_wr = wr_en & (idx == IDX_W'(i));

      // only two registers carry condition-dependent bits
      if (i == IDX_OSC) begin : g_osc
        assign cond_val[i] = osc_cond_i;
      end else if (i == IDX_CAUSE) begin : g_cause
        assign cond_val[i] = cause_cond_i;
      end else begin : g_nocond
        assign cond_val[i] = 8'h00;
      end

      // wake flags are write-one-to-clear, enables plain
      if (i == IDX_IRQ_CTRL) begin : g_irqw
        assign wr_val[i] = {wbyte[7:6], cur[5:0] & ~wbyte[5:0]};
        assign set_val[i] = {6'h00, cls_wake & wake_by_irq,
                             cls_wake & wake_by_wd};
      end else begin : g_plainw
        assign wr_val[i]  = wbyte;
        assign set_val[i] = 8'h00;
      end

      // top of stack takes the saved pc, pointer moves on
      if (i == IDX_STK_UPPER) begin : g_tu
        assign push_val[i] = {3'h0, pc_saved[20:16]};
      end else if (i == IDX_STK_HIGH) begin : g_th
        assign push_val[i] = pc_saved[15:8];
      end else if (i == IDX_STK_LOW) begin : g_tl
        assign push_val[i] = pc_saved[7:0];
      end else if (i == IDX_STK_PTR) begin : g_sp
        assign push_val[i] = {cur[7:5], nxt_sp_cnt};
      end else begin : g_nopush
        assign push_val[i] = cur;
      end

      assign this_push = push & (i >= IDX_STK_UPPER) & (i <= IDX_STK_PTR);

      // reset classes override a bus write in the same cycle
      assign base =
        cls_pwr   ? fold(cur, 8'h00, T_PWR_VAL[i], T_PWR_Q[i], cond_val[i]) :
        cls_brown ? fold(cur, T_BRN_KEEP[i], T_PWR_VAL[i], T_PWR_Q[i],
                         cond_val[i]) :
        cls_other ? fold(cur, T_OTH_KEEP[i], T_OTH_VAL[i], T_OTH_Q[i],
                         cond_val[i]) :
        cls_wake  ? fold(cur, T_WAK_KEEP[i], T_WAK_VAL[i], T_WAK_Q[i],
                         cond_val[i]) :
        this_wr   ? wr_val[i] :
        cur;

      // a wake flag set wins over a clear in the same cycle
      assign nxt_reg = ((this_push ? push_val[i] : base) | set_val[i])
                       & T_IMPL[i];

      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          regs_ff[i] <= T_PWR_VAL[i] & ~T_PWR_Q[i] & T_IMPL[i];
        end else begin
          regs_ff[i] <= nxt_reg;
        end
      end
    end
  endgenerate

  // tables drive the per-register behaviour: timer 0 config
  // timer 2 period timer 1 config voltage detect
  // timer 2 config cleared registers kept ones
  assign tmr_zero_config_o = regs_ff[IDX_T0_CONFIG];
  assign tmr_two_period_o  = regs_ff[IDX_T2_PERIOD];
  assign tmr_one_config_o  = regs_ff[IDX_T1_CONFIG];
  assign osc_config_o      = regs_ff[IDX_OSC];
  assign reset_cause_o     = regs_ff[IDX_CAUSE];
  assign stack_pointer_o   = sp_cnt;

  assign high_prio_global_irq_en_o = regs_ff[IDX_IRQ_CTRL][IRQ_GIE_HIGH_BIT];
  assign low_prio_global_irq_en_o  = regs_ff[IDX_IRQ_CTRL][IRQ_GIE_LOW_BIT];
  assign wake_flags_o = {regs_ff[IDX_IRQ_CTRL][IRQ_WAKE_IRQ_BIT],
                         regs_ff[IDX_IRQ_CTRL][IRQ_WAKE_WD_BIT]};

endmodule

// ### reset_init_value_bank_bench.sv
// self-checking bench for the reset and wake-up register bank
`timescale 1ns/100ps
module reset_init_value_bank_bench
  import reset_init_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [5:0]        ev = '0;
  logic              high_prio = 1'b1;
  logic              frees = 1'b0;
  logic [7:0]        pins = 8'hFF;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              pc_load;
  logic [PC_W-1:0]   pc_vector;
  logic [1:0]        flags;
  logic [7:0]        osc_cfg;
  logic [7:0]        t0_cfg;
  logic [7:0]        t2_per;
  logic [7:0]        cause;
  logic [4:0]        sp;
  logic [1:0]        gie;
  logic [7:0]        t1_cfg;
  logic [31:0]       rdat;
  logic              rerr;
  int                failures = 0;
  int                compares = 0;
  int                loads = 0;
  int                n0;

  reset_init_value_bank dut (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pwr_on_i(ev[0]), .brown_out_reset_i(ev[1]),
    .external_reset_pin_i(ev[2]), .other_reset_i(ev[3]), .watchdog_wake_i(ev[4]),
    .irq_wake_i(ev[5]), .irq_high_prio_i(high_prio), .pc_i(21'h1ABCDE),
    .osc_cond_i(8'hFF), .cause_cond_i(8'h50), .osc_frees_pins_i(frees),
    .port_a_pins_i(pins), .pc_load_o(pc_load), .pc_vector_o(pc_vector),
    .high_prio_global_irq_en_o(gie[1]), .low_prio_global_irq_en_o(gie[0]),
    .wake_flags_o(flags), .osc_config_o(osc_cfg), .tmr_zero_config_o(t0_cfg),
    .tmr_one_config_o(t1_cfg),
    .tmr_two_period_o(t2_per), .reset_cause_o(cause), .stack_pointer_o(sp));

  always #20 clk_i = ~clk_i;

  // vector loads are counted, so a missing or doubled pulse shows up
  always @(posedge clk_i) begin
    if (pc_load === 1'b1) begin
      loads++;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      wrap_up();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input int i);
    apb(1'b0, 8'(i * 4), 8'h00);
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, 8'(i * 4), d);
  endtask

  task automatic pulse(input int b, input int cyc);
    @(posedge clk_i);
    ev[b] <= 1'b1;
    repeat (cyc) @(posedge clk_i);
    ev[b] <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // kind: 0 reset input, 1 power-on, 2 brown-out, 3 other reset
  function automatic logic [7:0] exp_val(input int i, input int m);
    if (m >= 2 && i inside {0, 1, 3, 4, 5, 7, 13, 14, 19}) begin
      return T_IMPL[i];
    end
    case (i)
      8, 17: return 8'hFF;
      9: return m == 3 ? 8'h42 : (m == 0 ? 8'h40 : 8'h48);
      10: return 8'h05;
      12: return m == 3 ? 8'h53 : (m == 0 ? 8'h1C : 8'h5C);
      15: return m == 3 ? 8'hBF : 8'h00;
      default: return 8'h00;
    endcase
  endfunction

  // all-ones registers get zeros, so a reset must really reload them
  task automatic fill();
    logic [7:0] d;
    for (int i = 0; i < 29; i++) begin
      d = (i == 8 || i == 17) ? 8'h00 : 8'hFF;
      wr(i, d);
      rd(i);
      check($sformatf("reg %0d", i), rdat, 32'((i == 28) ? 8'hC0 : d & T_IMPL[i]));
    end
  endtask

  task automatic sweep(input int m);
    for (int i = 0; i < 29; i++) begin
      rd(i);
      check($sformatf("reg %0d/%0d", i, m), rdat, 32'(exp_val(i, m)));
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    sweep(0);
    for (int e = 0; e < 4; e++) begin
      fill();
      pulse(e, 2);
      sweep(e > 2 ? 3 : e + 1);
      $display("reset kind %0d done", e);
    end
    wr(9, 8'h00);
    wr(17, 8'h12);
    wr(8, 8'h5A);
    // stack count starts at 1F, so the first push must wrap to zero
    wr(27, 8'h1F);
    for (int k = 0; k < 3; k++) begin
      wr(28, k == 0 ? 8'h80 : (k == 1 ? 8'h43 : 8'h03));
      high_prio <= (k == 0);
      n0 = loads;
      pulse(5, 1);
      check("vector loads", 32'(loads - n0), k < 2 ? 1 : 0);
      check("vector", 32'(pc_vector), k == 0 ? 32'h08 : 32'h18);
      check("stack pointer", 32'(sp), k == 0 ? 0 : 1);
      check("wake flags", 32'(flags), 32'h2);
      check("irq enables", 32'(gie), k == 0 ? 32'h2 : (k == 1 ? 32'h1 : 32'h0));
    end
    for (int k = 0; k < 3; k++) begin
      rd(24 + k);
      check("stack top", rdat, k == 0 ? 32'h1A : (k == 1 ? 32'hBC : 32'hDE));
    end
    check("osc config", 32'(osc_cfg), 32'h02);
    check("reset cause", 32'(cause), 32'h53);
    check("timer 2 period", 32'(t2_per), 32'hFF);
    check("timer 0 config", 32'(t0_cfg), 32'h5A);
    check("timer 1 config", 32'(t1_cfg), 32'hBF);
    n0 = loads;
    pulse(4, 1);
    check("wake flags", 32'(flags), 32'h3);
    check("vector loads", 32'(loads - n0), 0);
    $display("wake tests done");
    rd(29);
    check("port a hidden", rdat, 32'h3F);
    frees <= 1'b1;
    pins <= 8'hA5;
    wr(29, 8'h00);
    rd(29);
    check("port a freed", rdat, 32'hA5);
    apb(1'b0, 8'h78, 8'h00);
    check("unmapped error", {rdat[30:0], rerr}, 32'h1);
    apb(1'b1, 8'h21, 8'hFF);
    check("unaligned error", 32'(rerr), 32'h1);
    $display("access tests done");
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    sweep(0);
    $display("second reset done");
    wrap_up();
  end
endmodule

// ### reset_init_value_bank_monitor.sv
// assertion checker for the reset and wake-up register bank
`timescale 1ns/100ps
module reset_init_value_bank_monitor
  import reset_init_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pwr_on_i,
  input wire logic              brown_out_reset_i,
  input wire logic              external_reset_pin_i,
  input wire logic              other_reset_i,
  input wire logic              watchdog_wake_i,
  input wire logic              irq_wake_i,
  input wire logic              osc_frees_pins_i,
  input wire logic              pc_load_o,
  input wire logic [PC_W-1:0]   pc_vector_o,
  input wire logic              high_prio_global_irq_en_o,
  input wire logic              low_prio_global_irq_en_o,
  input wire logic [1:0]        wake_flags_o,
  input wire logic [7:0]        tmr_zero_config_o,
  input wire logic [7:0]        tmr_one_config_o,
  input wire logic [7:0]        tmr_two_period_o,
  input wire logic [7:0]        reset_cause_o,
  input wire logic [4:0]        stack_pointer_o
);
  logic quiet;
  logic gie_any;
  logic any_reset;
  // the pin goes through a synchroniser, so it is kept out of the reset windows
  assign quiet     = !(pwr_on_i || brown_out_reset_i || external_reset_pin_i || other_reset_i);
  assign gie_any   = high_prio_global_irq_en_o || low_prio_global_irq_en_o;
  assign any_reset = pwr_on_i || brown_out_reset_i || other_reset_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_vector_load: assert property (irq_wake_i && quiet && gie_any |-> ##[1:4] pc_load_o)
    else $error("no vector load after irq wake");
  a_vector_value: assert property ($rose(pc_load_o) |->
    pc_vector_o == 21'h00008 || pc_vector_o == 21'h00018) else $error("bad wake vector");
  a_stack_push: assert property ($rose(pc_load_o) |->
    ##[0:2] (stack_pointer_o == $past(stack_pointer_o) + 5'h01)) else $error("no stack push");
  a_flag_irq: assert property (irq_wake_i && quiet |-> ##[1:3] wake_flags_o[1])
    else $error("irq wake flag not set");
  a_flag_wd: assert property (watchdog_wake_i && quiet |-> ##[1:3] wake_flags_o[0])
    else $error("watchdog wake flag not set");
  a_upper_zero: assert property (prdata_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_port_hidden: assert property (psel_i && penable_i && paddr_i == 8'h74
    && !$past(osc_frees_pins_i) |-> prdata_o[7:6] == 2'b00) else $error("port bits 7:6 seen");
  a_t0cfg_ones: assert property (any_reset |-> ##[2:3] tmr_zero_config_o == 8'hFF)
    else $error("timer 0 config not all ones");
  a_period_ones: assert property (any_reset || watchdog_wake_i || irq_wake_i
    |-> ##[2:3] tmr_two_period_o == 8'hFF) else $error("timer 2 period not all ones");
  a_t1cfg_bit6: assert property (other_reset_i |-> ##[2:3] !tmr_one_config_o[6])
    else $error("timer 1 config bit 6 kept");
  a_cause_pwr: assert property (pwr_on_i |-> ##[2:3] (reset_cause_o & 8'hBD) == 8'h1C)
    else $error("reset cause power-on pattern wrong");
endmodule

bind reset_init_value_bank reset_init_value_bank_monitor u_mon (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pwr_on_i(pwr_on_i),
  .brown_out_reset_i(brown_out_reset_i), .external_reset_pin_i(external_reset_pin_i),
  .other_reset_i(other_reset_i), .watchdog_wake_i(watchdog_wake_i),
  .irq_wake_i(irq_wake_i), .osc_frees_pins_i(osc_frees_pins_i), .pc_load_o(pc_load_o),
  .pc_vector_o(pc_vector_o), .high_prio_global_irq_en_o(high_prio_global_irq_en_o),
  .low_prio_global_irq_en_o(low_prio_global_irq_en_o), .wake_flags_o(wake_flags_o),
  .tmr_zero_config_o(tmr_zero_config_o), .tmr_one_config_o(tmr_one_config_o),
  .tmr_two_period_o(tmr_two_period_o), .reset_cause_o(reset_cause_o),
  .stack_pointer_o(stack_pointer_o));

// ### wake_vector_unit.sv
// interrupt wake-up: vector load and stack push request
`timescale 1ns/100ps
module wake_vector_unit
  import reset_init_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  input  wire logic            cls_wake_i,
  input  wire logic            wake_by_irq_i,
  input  wire logic            gie_high_i,
  input  wire logic            gie_low_i,
  input  wire logic            irq_high_prio_i,
  input  wire logic [PC_W-1:0] pc_i,
  output logic                 push_o,
  output logic                 pc_load_o,
  output logic [PC_W-1:0]      pc_saved_o,
  output logic [PC_W-1:0]      pc_vector_o
);

  logic take_vector;

  // with both enables clear the core just resumes at the next word
  assign take_vector = cls_wake_i & wake_by_irq_i & (gie_high_i | gie_low_i);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      push_o      <= 1'b0;
      pc_load_o   <= 1'b0;
      pc_saved_o  <= '0;
      pc_vector_o <= '0;
    end else begin
      push_o    <= take_vector;
      pc_load_o <= take_vector;
      if (take_vector) begin
        pc_saved_o  <= pc_i;
        pc_vector_o <= irq_high_prio_i ? VEC_HIGH_PRIO : VEC_LOW_PRIO;
      end
    end
  end

endmodule
